// file: bsd_pkg.sv
// Constants, cell layout and state codes of the boundary-scan data register block.
// Assumes one system clock domain; the scan port pins are sampled, not used as clocks.
package bsd_pkg;
	localparam int IOB_COUNT = 8;
	localparam int TAP_PAD_COUNT = 3;
	localparam int GCLK_PAD = 3;
	localparam int CELLS_PER_IOB = 3;
	localparam int TDO_T_BIT = 0;
	localparam int TDO_O_BIT = 1;
	localparam int IOB_BASE = 2;
	localparam int TRI_OFS = 0;
	localparam int OUT_OFS = 1;
	localparam int IN_OFS = 2;
	localparam int DIN_BIT = IOB_BASE + CELLS_PER_IOB * IOB_COUNT;
	localparam int DOUT_BIT = DIN_BIT + 1;
	localparam int UPD_BIT = DOUT_BIT + 1;
	localparam int BSR_LEN = UPD_BIT + 1;
	localparam int IR_LEN = 3;
	localparam logic [2:0] INS_EXTEST = 3'h0;
	localparam logic [2:0] INS_SAMPLE = 3'h1;
	localparam logic [2:0] INS_USER_1 = 3'h2;
	localparam logic [2:0] INS_USER_2 = 3'h3;
	localparam logic [2:0] INS_READBACK = 3'h4;
	localparam logic [2:0] INS_CONFIGURE = 3'h5;
	localparam logic [2:0] INS_RESERVED = 3'h6;
	localparam logic [2:0] INS_BYPASS = 3'h7;
	localparam logic [2:0] IR_CAPTURE = 3'h1;
	localparam int AXI_ADDR_W = 4;
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;
	localparam int CTRL_KEEP_BIT = 0;
	localparam int CTRL_GCLK_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_IR_LSB = 4;
	localparam int STAT_EN_BIT = 7;
	typedef enum logic [3:0] {
		TAP_RESET = 4'h0,
		TAP_IDLE = 4'h1,
		TAP_SEL_DR = 4'h2,
		TAP_CAP_DR = 4'h3,
		TAP_SHIFT_DR = 4'h4,
		TAP_EXIT1_DR = 4'h5,
		TAP_PAUSE_DR = 4'h6,
		TAP_EXIT2_DR = 4'h7,
		TAP_UPD_DR = 4'h8,
		TAP_SEL_IR = 4'h9,
		TAP_CAP_IR = 4'hA,
		TAP_SHIFT_IR = 4'hB,
		TAP_EXIT1_IR = 4'hC,
		TAP_PAUSE_IR = 4'hD,
		TAP_EXIT2_IR = 4'hE,
		TAP_UPD_IR = 4'hF
	} bsd_tap_state_t;
endpackage

// file: bsd_tap_ctl.sv
// Model of the external scan controller driving tck, tms and tdi.
// Assumes tck halves of 40 ns; tck stands low between frames.
`timescale 1ns/1ps
module bsd_tap_ctl (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// Tdo is read just before the rise, so it has settled since the last fall.
	task automatic clk1(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#40;
		q = tdo;
		tck = 1'b1;
		#40;
		tck = 1'b0;
	endtask
	// Outside shifting tdi is treated as released and keeps toggling.
	task automatic step(input logic m);
		logic q;
		clk1(m, ~tdi, q);
	endtask
	task automatic reset_idle();
		#3;
		repeat (5) step(1'b1);
		step(1'b0);
	endtask
	task automatic idle_run(input int k);
		#3;
		repeat (k) step(1'b0);
	endtask
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic q;
		#3;
		dout = '0;
		step(1'b1);
		if (ir) step(1'b1);
		step(1'b0);
		step(1'b0);
		for (int i = 0; i < n; i++) begin
			clk1(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1);
		step(1'b0);
	endtask
endmodule

// file: bsd_top.sv
// Boundary-scan TAP, boundary register, bypass and user register hooks, with AXI4-Lite control.
// Assumes TCK, TMS, TDI and pad inputs are asynchronous; fabric and config signals share clk_sys.
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module bsd_top (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe_n,
	input wire logic [bsd_pkg::IOB_COUNT-1:0] pad_in,
	output logic [bsd_pkg::IOB_COUNT-1:0] pad_out,
	output logic [bsd_pkg::IOB_COUNT-1:0] pad_oe_n,
	input wire logic [bsd_pkg::IOB_COUNT-1:0] core_out,
	input wire logic [bsd_pkg::IOB_COUNT-1:0] core_oe,
	output logic [bsd_pkg::IOB_COUNT-1:0] core_in,
	input wire logic ded_in,
	output logic core_ded_in,
	input wire logic core_ded_out,
	output logic ded_out,
	input wire logic config_done,
	input wire logic config_dout,
	input wire logic readback_data,
	output logic config_data_in,
	output logic config_shift,
	output logic readback_shift,
	output logic update_test_cell,
	output logic user_select_1,
	output logic user_select_2,
	input wire logic user_return_1,
	input wire logic user_return_2,
	output logic user_dr_clock,
	output logic idle_gated_clock,
	input wire logic [bsd_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [bsd_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import bsd_pkg::*;

	function automatic bsd_tap_state_t tap_next(input bsd_tap_state_t s, input logic m);
		case (s)
			TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			default: tap_next = TAP_RESET;
		endcase
	endfunction

	// Boundary register instructions share capture, shift and update handling.
	function automatic logic uses_bsr(input logic [2:0] code);
		uses_bsr = (code == INS_EXTEST) || (code == INS_SAMPLE);
	endfunction

	logic [2:0] tck_m;
	logic [1:0] tms_m;
	logic [1:0] tdi_m;
	logic tck_s;
	logic tck_q;
	logic tms_s;
	logic tdi_s;
	logic [IOB_COUNT-1:0] pad_m;
	logic [IOB_COUNT-1:0] pad_s;
	logic ded_m;
	logic ded_s;
	logic tck_rise;
	logic tck_fall;
	bsd_tap_state_t state;
	logic [2:0] ir;
	logic [2:0] ir_sr;
	logic [BSR_LEN-1:0] bsr_sr;
	logic [BSR_LEN-1:0] bsr_upd;
	logic [BSR_LEN-1:0] cap_vec;
	logic byp;
	logic tdo_next;
	logic [1:0] ctrl;
	logic tap_enabled;
	logic ext_mode;
	logic cfg_mode;
	logic user_ins;

	// Two-stage synchronisers; tck edge detection compares the second stage with a third tck stage.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tck_m <= 3'h0;
			tms_m <= 2'h0;
			tdi_m <= 2'h0;
			pad_m <= '0;
			pad_s <= '0;
			ded_m <= 1'b0;
			ded_s <= 1'b0;
		end else begin
			tck_m <= {tck_m[1:0], tck};
			tms_m <= {tms_m[0], tms};
			tdi_m <= {tdi_m[0], tdi};
			pad_m <= pad_in;
			pad_s <= pad_m;
			ded_m <= ded_in;
			ded_s <= ded_m;
		end
	end

	assign tck_s = tck_m[1];
	assign tck_q = tck_m[2];
	assign tms_s = tms_m[1];
	assign tdi_s = tdi_m[1];
	// The TAP works from the synchronised pins, never from boundary register contents.
	assign tck_rise = tck_s & ~tck_q;
	assign tck_fall = ~tck_s & tck_q;

	// Once configured, the scan port survives only if software says the macro is present.
	assign tap_enabled = ~config_done | ctrl[CTRL_KEEP_BIT];
	assign ext_mode = tap_enabled && (ir == INS_EXTEST);
	assign cfg_mode = tap_enabled && (ir == INS_CONFIGURE);
	assign user_ins = (ir == INS_USER_1) || (ir == INS_USER_2);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state <= TAP_RESET;
		end else if (!tap_enabled) begin
			state <= TAP_RESET;
		end else if (tck_rise) begin
			state <= tap_next(state, tms_s);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ir_sr <= INS_BYPASS;
			ir <= INS_BYPASS;
		end else if (state == TAP_RESET) begin
			ir_sr <= INS_BYPASS;
			ir <= INS_BYPASS;
		end else if (tck_rise && state == TAP_CAP_IR) begin
			ir_sr <= IR_CAPTURE;
		end else if (tck_rise && state == TAP_SHIFT_IR) begin
			ir_sr <= {tdi_s, ir_sr[2:1]};
		end else if (tck_fall && state == TAP_UPD_IR) begin
			ir <= ir_sr;
		end
	end

	assign cap_vec[TDO_T_BIT] = ~tdo_oe_n;
	assign cap_vec[TDO_O_BIT] = tdo;
	// Index order follows the die edges: top, left, bottom, right from the TDO end.
	genvar gi;
	generate
		for (gi = 0; gi < IOB_COUNT; gi++) begin : g_cap
			assign cap_vec[IOB_BASE + CELLS_PER_IOB * gi + TRI_OFS] = ~pad_oe_n[gi];
			assign cap_vec[IOB_BASE + CELLS_PER_IOB * gi + OUT_OFS] = pad_out[gi];
			assign cap_vec[IOB_BASE + CELLS_PER_IOB * gi + IN_OFS] = pad_s[gi];
		end
	endgenerate
	// Configuration pins have no entry here at all.
	assign cap_vec[DIN_BIT] = ded_s;
	assign cap_vec[DOUT_BIT] = ded_out;
	assign cap_vec[UPD_BIT] = bsr_upd[UPD_BIT];

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			bsr_sr <= '0;
		end else if (tck_rise && uses_bsr(ir)) begin
			if (state == TAP_CAP_DR) begin
				bsr_sr <= cap_vec;
			end else if (state == TAP_SHIFT_DR) begin
				bsr_sr <= {tdi_s, bsr_sr[BSR_LEN-1:1]};
			end
		end
	end

	// Update lands on the falling edge so pads change while TCK is low.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			bsr_upd <= '0;
		end else if (tck_fall && state == TAP_UPD_DR && uses_bsr(ir)) begin
			bsr_upd <= bsr_sr;
		end
	end

	// The reserved code behaves as bypass so the chain length stays defined.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			byp <= 1'b0;
		end else if (tck_rise && (ir == INS_BYPASS || ir == INS_RESERVED)) begin
			if (state == TAP_CAP_DR) begin
				byp <= 1'b0;
			end else if (state == TAP_SHIFT_DR) begin
				byp <= tdi_s;
			end
		end
	end

	always_comb begin
		tdo_next = byp;
		if (state == TAP_SHIFT_IR) begin
			tdo_next = ir_sr[0];
		end else begin
			case (ir)
				INS_EXTEST: tdo_next = bsr_sr[0];
				INS_SAMPLE: tdo_next = bsr_sr[0];
				INS_USER_1: tdo_next = user_return_1;
				INS_USER_2: tdo_next = user_return_2;
				INS_READBACK: tdo_next = readback_data;
				INS_CONFIGURE: tdo_next = config_dout;
				default: tdo_next = byp;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tdo <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else if (!tap_enabled) begin
			tdo <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else if (tck_fall) begin
			tdo <= tdo_next;
			tdo_oe_n <= ~(state == TAP_SHIFT_DR || state == TAP_SHIFT_IR);
		end
	end

	generate
		for (gi = 0; gi < IOB_COUNT; gi++) begin : g_pad
			localparam bit IS_TAP = (gi < TAP_PAD_COUNT);
			localparam bit IS_GCLK = (gi == GCLK_PAD);
			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					pad_out[gi] <= 1'b0;
					pad_oe_n[gi] <= 1'b1;
					core_in[gi] <= 1'b0;
				end else begin
					pad_out[gi] <= ext_mode ?
						bsr_upd[IOB_BASE + CELLS_PER_IOB * gi + OUT_OFS] : core_out[gi];
					if (cfg_mode || (IS_TAP && tap_enabled)) begin
						pad_oe_n[gi] <= 1'b1;
					end else if (ext_mode) begin
						pad_oe_n[gi] <= ~bsr_upd[IOB_BASE + CELLS_PER_IOB * gi + TRI_OFS];
					end else begin
						pad_oe_n[gi] <= ~core_oe[gi];
					end
					// A clock pad is protected only while it really feeds a global clock.
					if (ext_mode && !IS_TAP && !(IS_GCLK && ctrl[CTRL_GCLK_BIT])) begin
						core_in[gi] <= bsr_upd[IOB_BASE + CELLS_PER_IOB * gi + IN_OFS];
					end else begin
						core_in[gi] <= pad_s[gi];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			core_ded_in <= 1'b0;
			ded_out <= 1'b0;
			update_test_cell <= 1'b0;
		end else begin
			core_ded_in <= ext_mode ? bsr_upd[DIN_BIT] : ded_s;
			ded_out <= ext_mode ? bsr_upd[DOUT_BIT] : core_ded_out;
			update_test_cell <= bsr_upd[UPD_BIT];
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			config_data_in <= 1'b0;
			config_shift <= 1'b0;
			readback_shift <= 1'b0;
		end else begin
			config_data_in <= tdi_s;
			config_shift <= tck_rise && state == TAP_SHIFT_DR && cfg_mode;
			readback_shift <= tck_rise && state == TAP_SHIFT_DR && ir == INS_READBACK;
		end
	end

	// The exported clocks are resampled TCK, so they lag the pin by three cycles.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			user_select_1 <= 1'b0;
			user_select_2 <= 1'b0;
			user_dr_clock <= 1'b1;
			idle_gated_clock <= 1'b1;
		end else begin
			user_select_1 <= tap_enabled && ir == INS_USER_1;
			user_select_2 <= tap_enabled && ir == INS_USER_2;
			if (user_ins && (state == TAP_CAP_DR || state == TAP_SHIFT_DR)) begin
				user_dr_clock <= tck_s;
			end else begin
				user_dr_clock <= 1'b1;
			end
			idle_gated_clock <= ~(tck_s & (state == TAP_IDLE));
		end
	end

	logic aw_have;
	logic w_have;
	logic next_aw_have;
	logic next_w_have;
	logic do_write;
	logic [AXI_ADDR_W-1:0] aw_q;
	logic [31:0] w_q;
	logic w_lane0;

	assign do_write = aw_have && w_have && !s_axi_bvalid;
	assign next_aw_have = (aw_have && !do_write) || (s_axi_awvalid && s_axi_awready);
	assign next_w_have = (w_have && !do_write) || (s_axi_wvalid && s_axi_wready);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_q <= '0;
			w_q <= 32'h0;
			w_lane0 <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			aw_have <= next_aw_have;
			w_have <= next_w_have;
			s_axi_awready <= !next_aw_have;
			s_axi_wready <= !next_w_have;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= s_axi_wdata;
				w_lane0 <= s_axi_wstrb[0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl <= CTRL_RESET;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			if (aw_q == CTRL_OFS) begin
				s_axi_bresp <= RESP_OKAY;
				if (w_lane0) begin
					ctrl <= w_q[1:0];
				end
			end else if (aw_q == STAT_OFS) begin
				s_axi_bresp <= RESP_OKAY;
			end else begin
				s_axi_bresp <= RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
			if (s_axi_araddr == CTRL_OFS) begin
				s_axi_rdata[1:0] <= ctrl;
			end else if (s_axi_araddr == STAT_OFS) begin
				s_axi_rdata[STAT_STATE_LSB +: 4] <= state;
				s_axi_rdata[STAT_IR_LSB +: IR_LEN] <= ir;
				s_axi_rdata[STAT_EN_BIT] <= tap_enabled;
			end else begin
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule

// file: bsd_top_assertions.sv
// Port checker for bsd_top, attached by bind.
// Assumes it sees only the ports of bsd_top in the clk_sys domain.
`timescale 1ns/1ps
module bsd_chk (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic tck,
	input wire logic tdo,
	input wire logic tdo_oe_n,
	input wire logic [bsd_pkg::IOB_COUNT-1:0] pad_oe_n,
	input wire logic config_shift,
	input wire logic readback_shift,
	input wire logic user_select_1,
	input wire logic user_select_2,
	input wire logic user_dr_clock,
	input wire logic idle_gated_clock,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import bsd_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_sel_exclusive: assert property (!(user_select_1 && user_select_2))
		else $error("both user selects high");
	a_tap_pads_off: assert property (!tdo_oe_n |-> &pad_oe_n[2:0])
		else $error("scan port pad driven while scanning");
	a_cfg_pads_off: assert property (config_shift |-> &pad_oe_n)
		else $error("pad driven under configure");
	a_cfg_pulse: assert property (config_shift |=> !config_shift)
		else $error("config shift wider than one cycle");
	a_rb_pulse: assert property (readback_shift |-> !config_shift ##1 !readback_shift)
		else $error("readback shift malformed");
	a_tdo_on_fall: assert property (($changed(tdo) || $changed(tdo_oe_n)) |-> !$past(tck))
		else $error("tdo moved while tck high");
	a_udclk_quiet: assert property (!user_select_1 && !user_select_2 |-> user_dr_clock)
		else $error("user clock toggles without user instruction");
	a_idle_not_shift: assert property (!tdo_oe_n |-> idle_gated_clock)
		else $error("idle clock low outside idle");
	a_idle_after_tck: assert property ($fell(idle_gated_clock) |-> $past(tck) || $past(tck, 2))
		else $error("idle clock fell without tck high");
	a_wr_resp: assert property (s_wr_take |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rd_resp: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
endmodule
bind bsd_top bsd_chk i_bsd_chk (.*);

// file: bsd_top_tb_top.sv
// Self-checking bench for bsd_top: scan frames and AXI4-Lite register traffic.
// Assumes the controller model in bsd_tap_ctl and the bound port checker.
`timescale 1ns/1ps
module bsd_top_tb_top;
	import bsd_pkg::*;
	logic clk_sys, resetn, tck, tms, tdi, tdo, tdo_oe_n;
	logic [7:0] pad_in, pad_out, pad_oe_n, core_out, core_oe, core_in, pad_ext, tp, op, ip, pin;
	logic ded_in, core_ded_in, core_ded_out, ded_out, config_done, config_dout, readback_data;
	logic config_data_in, config_shift, readback_shift, update_test_cell, user_select_1;
	logic user_select_2, user_return_1, user_return_2, user_dr_clock, idle_gated_clock, b;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, q, p, seed;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int n_fail, checks_done, n_ud, n_ig, n_rb, n_cf, c0, c1;
	bsd_top i_bsd_top (.*);
	bsd_tap_ctl i_bsd_tap_ctl (.*);
	// A driven pad shows its own drive; otherwise the outside source is seen.
	assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & pad_ext);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		n_ud += int'($fell(user_dr_clock));
		n_ig += int'($fell(idle_gated_clock));
		n_rb += int'(readback_shift);
		n_cf += int'(config_shift);
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [31:0] cells(input logic [7:0] t, o, n, input logic a, e);
		logic [31:0] v;
		v = '0;
		for (int i = 0; i < 8; i++) begin
			v[2 + 3 * i] = t[i];
			v[3 + 3 * i] = o[i];
			v[4 + 3 * i] = n[i];
		end
		v[DIN_BIT] = a;
		v[DOUT_BIT] = e;
		return v;
	endfunction
	task automatic end_sim();
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (!ok) begin
			n_fail++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
		int t;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		t = 0;
		do begin
			@(posedge clk_sys);
			t++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bready && s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				r = s_axi_bresp;
			end
		end while ((s_axi_awvalid || s_axi_wvalid || s_axi_bready) && t < 60);
		if (t >= 60) begin
			chk(1'b0, "write hung");
			end_sim();
		end
	endtask
	task automatic rd(input logic [3:0] a);
		int t;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		t = 0;
		do begin
			@(posedge clk_sys);
			t++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rready && s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				d = s_axi_rdata;
				r = s_axi_rresp;
			end
		end while ((s_axi_arvalid || s_axi_rready) && t < 60);
		if (t >= 60) begin
			chk(1'b0, "read hung");
			end_sim();
		end
	endtask
	initial begin
		{resetn, pad_ext, core_out, core_oe, ded_in, core_ded_out, config_done} = '0;
		{config_dout, readback_data, user_return_1, user_return_2, s_axi_awaddr} = '0;
		{s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, n_fail, checks_done} = '0;
		{n_ud, n_ig, n_rb, n_cf} = '0;
		seed = 32'h627B;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rd(CTRL_OFS);
		chk(d === 32'h2 && r === RESP_OKAY, "ctrl reset value");
		rd(STAT_OFS);
		chk(d === {24'h0, 1'b1, INS_BYPASS, TAP_RESET}, "status after reset");
		rd(4'h8);
		chk(d === 32'h0 && r === RESP_SLVERR, "unmapped read");
		wr(4'hC, 32'h3, 4'hF);
		chk(r === RESP_SLVERR, "unmapped write");
		wr(CTRL_OFS, 32'h1, 4'h0);
		rd(CTRL_OFS);
		chk(d === 32'h2, "write without strobe");
		$display("register test done");
		i_bsd_tap_ctl.reset_idle();
		i_bsd_tap_ctl.scan(1'b1, 3, INS_BYPASS, q);
		chk(q[2:0] === IR_CAPTURE, "instruction capture");
		for (int k = 6; k < 8; k++) begin
			i_bsd_tap_ctl.scan(1'b1, 3, 3'(k), q);
			seed = xs(seed);
			i_bsd_tap_ctl.scan(1'b0, 16, seed, q);
			chk(q[15:0] === {seed[14:0], 1'b0}, "bypass path");
		end
		$display("bypass test done");
		@(posedge clk_sys);
		seed = xs(seed);
		core_out <= seed[7:0];
		core_oe <= seed[15:8];
		pad_ext <= seed[23:16];
		ded_in <= seed[24];
		core_ded_out <= seed[25];
		i_bsd_tap_ctl.scan(1'b1, 3, INS_SAMPLE, q);
		tp = core_oe & 8'hF8;
		pin = (tp & core_out) | (~tp & pad_ext);
		chk(core_in === pin && core_ded_in === ded_in, "sample pin path");
		seed = xs(seed);
		{ip, op, tp} = seed[23:0];
		p = cells(tp, op, ip, 1'b0, seed[24]) | 32'h1000_0000;
		i_bsd_tap_ctl.scan(1'b0, BSR_LEN, p, q);
		d = cells(core_oe & 8'hF8, core_out, pin, ded_in, core_ded_out);
		chk((q & 32'h0FFF_FFFC) === d, "sample capture");
		chk(update_test_cell === 1'b1, "update cell last");
		i_bsd_tap_ctl.scan(1'b1, 3, INS_EXTEST, q);
		tp = tp & 8'hF8;
		pin = (tp & op) | (~tp & pad_ext);
		chk(pad_oe_n === (~tp | 8'h07) && (pad_out & tp) === (op & tp), "extest drive");
		chk(core_in === {ip[7:4], pin[3:0]} && ded_out === seed[24], "extest in");
		wr(CTRL_OFS, 32'h0, 4'h1);
		// The pad register follows the control write one edge later.
		repeat (2) @(posedge clk_sys);
		chk(core_in[3] === ip[3], "clock pad as data");
		i_bsd_tap_ctl.scan(1'b0, BSR_LEN, p, q);
		chk((q & 32'h0FFF_FFFC) === cells(tp, op, pin, ded_in, seed[24]), "extest capture");
		$display("boundary test done");
		@(posedge clk_sys);
		user_return_1 <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			i_bsd_tap_ctl.scan(1'b1, 3, INS_USER_1 + 3'(k), q);
			chk(user_select_1 === (k == 0) && user_select_2 === (k == 1), "user select");
			c0 = n_ud;
			i_bsd_tap_ctl.scan(1'b0, 8, seed, q);
			chk(q[7:0] === {8{k == 0}}, "user return data");
			chk(n_ud - c0 >= 8, "user clock count");
		end
		c0 = n_ig;
		i_bsd_tap_ctl.idle_run(6);
		chk(n_ig - c0 >= 6, "idle clock count");
		$display("user test done");
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_sys);
			seed = xs(seed);
			b = seed[0];
			readback_data <= b;
			config_dout <= ~b;
			i_bsd_tap_ctl.scan(1'b1, 3, INS_READBACK + 3'(k), q);
			chk(k == 0 || pad_oe_n === 8'hFF, "configure pads off");
			{c0, c1} = {n_rb, n_cf};
			i_bsd_tap_ctl.scan(1'b0, 8, seed, q);
			chk(q[7:0] === {8{b ^ k[0]}}, "tdo source");
			chk(n_rb - c0 === 8 * (1 - k) && n_cf - c1 === 8 * k, "shift pulses");
			chk(config_data_in === tdi, "config data follows tdi");
		end
		$display("config test done");
		@(posedge clk_sys);
		config_done <= 1'b1;
		i_bsd_tap_ctl.scan(1'b1, 3, INS_USER_1, q);
		chk(user_select_1 === 1'b0 && pad_oe_n[2:0] === ~core_oe[2:0], "tap released");
		wr(CTRL_OFS, 32'h1, 4'h1);
		i_bsd_tap_ctl.reset_idle();
		i_bsd_tap_ctl.scan(1'b1, 3, INS_USER_1, q);
		chk(user_select_1 === 1'b1, "scan kept");
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rd(CTRL_OFS);
		chk(d === 32'h2 && user_select_1 === 1'b0, "second reset");
		$display("release test done");
		end_sim();
	end
endmodule
